// [include/ocs_pkg.sv]
// Shared constants and types for one overcurrent stage with event recording.
// Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register port.
package ocs_pkg;
	// Timing: a millisecond time stamp and a 5 ms program cycle
	localparam int CLK_KHZ = 200000;
	localparam int STAMP_MS = 1;
	localparam int MS_CYCLES = STAMP_MS * CLK_KHZ;
	localparam int TICK_MS = 5;
	localparam int BLOCK_LEAD_MS = 5;
	localparam int PRE_TRIG_MS = 20;
	localparam int PRE_FAULT_MS = 200;
	localparam int PRE_TRIG_TICKS = PRE_TRIG_MS / TICK_MS;
	localparam int PRE_FAULT_TICKS = PRE_FAULT_MS / TICK_MS;
	localparam int MAX_TRIP_S = 1800;
	localparam int REMAIN_MAX_TICKS = MAX_TRIP_S * 1000 / TICK_MS;
	// Pick-up hysteresis: release below 97 % of the level
	localparam int REL_PCT = 97;
	localparam int FULL_PCT = 100;
	localparam int HIST_DEPTH = 12;
	localparam int NUM_STAT = 9;
	localparam int NUM_EVT = 2 * NUM_STAT;
	localparam int TW = 19;
	localparam int AW = 8;

	// Register byte offsets
	localparam logic [AW-1:0] REG_CTRL = 8'h00;
	localparam logic [AW-1:0] REG_EVMASK = 8'h04;
	localparam logic [AW-1:0] REG_PICKUP = 8'h08;
	localparam logic [AW-1:0] REG_HARM = 8'h0C;
	localparam logic [AW-1:0] REG_DELAY = 8'h10;
	localparam logic [AW-1:0] REG_RELEASE = 8'h14;
	localparam logic [AW-1:0] REG_STATUS = 8'h18;
	localparam logic [AW-1:0] REG_CNT_START = 8'h1C;
	localparam logic [AW-1:0] REG_CNT_TRIP = 8'h20;
	localparam logic [AW-1:0] REG_CNT_BLOCK = 8'h24;
	localparam logic [AW-1:0] REG_HIST_SEL = 8'h28;
	localparam logic [AW-1:0] REG_HIST_STAMP = 8'h2C;
	localparam logic [AW-1:0] REG_HIST_INFO = 8'h30;
	localparam logic [AW-1:0] REG_HIST_CUR = 8'h34;
	localparam logic [AW-1:0] REG_HIST_PRE = 8'h38;
	localparam logic [AW-1:0] REG_HIST_REM = 8'h3C;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Control bits and reset values
	localparam int CTRL_INV_BIT = 0;
	localparam int CTRL_INRUSH_BIT = 1;
	localparam int CTRL_CLR_BIT = 2;
	localparam logic [15:0] PICKUP_RST = 16'h0078;
	localparam logic [15:0] HARM_LIM_RST = 16'h0001;
	localparam logic [TW-1:0] DELAY_RST = 19'h000C8;
	localparam logic [TW-1:0] RELEASE_RST = 19'h00000;
	localparam logic [NUM_EVT-1:0] EVMASK_RST = 18'h3FFFF;

	// Event codes: even is the assertion, odd the deassertion
	localparam logic [4:0] EV_START_ON = 5'h00;
	localparam logic [4:0] EV_TRIP_ON = 5'h02;
	localparam logic [4:0] EV_BLOCK_ON = 5'h04;

	typedef logic [2:0][15:0] ocs_phase_t;
	// Bit order matches event code / 2
	typedef struct packed {
		logic [2:0] ph_trip;
		logic [2:0] ph_start;
		logic blocked;
		logic trip;
		logic start;
	} ocs_stat_t;
	typedef struct packed {
		logic [31:0] stamp;
		logic [4:0] evt;
		logic [2:0] phases;
		logic [15:0] pre_trig;
		logic [15:0] fault;
		logic [15:0] pre_fault;
		logic [TW-1:0] remain;
		logic [2:0] group;
	} ocs_rec_t;
endpackage : ocs_pkg

// [core/ocs_history.sv]
// Twelve-entry circular record store; the newest record is age 0.
// Assumes at most one write per cycle; unfilled ages read as zero.
`timescale 1ns/1ps
module ocs_history
	import ocs_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr_en,
	input wire ocs_rec_t wr_rec,
	input wire logic [3:0] rd_age,
	output ocs_rec_t rd_rec,
	output logic [3:0] fill
);
	ocs_rec_t mem [HIST_DEPTH];
	logic [3:0] wp_r;
	logic [4:0] rd_sum;
	logic [3:0] rd_idx;

	// Oldest entry is overwritten once all twelve are used
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wp_r <= 4'h0;
			fill <= 4'h0;
		end else if (wr_en) begin
			wp_r <= (wp_r == 4'(HIST_DEPTH - 1)) ? 4'h0 : wp_r + 4'h1;
			if (fill != 4'(HIST_DEPTH))
				fill <= fill + 4'h1;
		end
	end

	// Storage needs no reset; fill count hides stale words
	always_ff @(posedge aclk) begin
		if (wr_en)
			mem[wp_r] <= wr_rec;
	end

	// Age to slot: newest sits just behind the write pointer
	always_comb begin
		rd_sum = {1'b0, wp_r} + 5'(HIST_DEPTH - 1) - {1'b0, rd_age};
		rd_idx = (rd_sum >= 5'(HIST_DEPTH)) ? 4'(rd_sum - 5'(HIST_DEPTH)) : rd_sum[3:0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			rd_rec <= '0;
		else
			rd_rec <= (rd_age < fill) ? mem[rd_idx] : '0;
	end
endmodule : ocs_history

// [core/ocs_stage.sv]
// One overcurrent stage: pick-up, blocking, delay timing, events, counters, history.
// Assumes phase magnitudes and harmonic ratios arrive synchronous to aclk.
`timescale 1ns/1ps
module ocs_stage
	import ocs_pkg::*;
#(
	parameter int MS_CYC = MS_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire ocs_phase_t measured_magnitude,
	input wire ocs_phase_t harm_ratio,
	input wire logic block_in,
	input wire logic [2:0] group_in,
	output ocs_stat_t stat_o,
	output logic evt_valid,
	output logic [4:0] evt_code,
	output logic [31:0] evt_stamp
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic aw_hold_r, w_hold_r, wr_fire, wr_ok, rd_ok, cnt_clr, tick, ms_pulse;
	logic [AW-1:0] aw_addr_r;
	logic [31:0] w_data_r, wr_old, wr_word, rd_word, stamp_r, cyc_r;
	logic [3:0] w_strb_r, hist_sel_r;
	logic [2:0] tick_ms_r;
	logic inv_mode_r, inrush_en_r, harm_blk, any_pk, start_nxt, blocked_nxt, trip_nxt, done;
	logic [15:0] pickup_r, harm_lim_r, max_mag;
	logic [TW-1:0] delay_r, release_r, elapsed_r, rel_r, elapsed_inc, remain_nxt, remain_r;
	logic [39:0] acc_r, acc_inc, thr;
	logic [NUM_EVT-1:0] evmask_r, pend_r, ev_set, ev_clr;
	logic [2:0] pk_r, pk_nxt, harm_over;
	ocs_stat_t stat_r, stat_nxt, rise, ev_chg;
	logic [31:0] cnt_r [3];
	logic [15:0] cur_hist [PRE_FAULT_TICKS];
	logic [5:0] hp_r, pre_idx;
	logic rec_wr_r;
	ocs_rec_t rec_r, hist_rec;

	// Byte-lane merge for partial writes
	function automatic logic [31:0] ocs_wmask(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction : ocs_wmask

	// Register decode shared by the read path and the write merge
	function automatic logic [32:0] ocs_read(input logic [AW-1:0] a);
		unique case (a)
			REG_CTRL: return {1'b1, 30'h0, inrush_en_r, inv_mode_r};
			REG_EVMASK: return {1'b1, 14'h0, evmask_r};
			REG_PICKUP: return {1'b1, 16'h0, pickup_r};
			REG_HARM: return {1'b1, 16'h0, harm_lim_r};
			REG_DELAY: return {1'b1, 13'h0, delay_r};
			REG_RELEASE: return {1'b1, 13'h0, release_r};
			REG_STATUS: return {1'b1, 3'h0, remain_r, 1'b0, stat_r};
			REG_CNT_START: return {1'b1, cnt_r[0]};
			REG_CNT_TRIP: return {1'b1, cnt_r[1]};
			REG_CNT_BLOCK: return {1'b1, cnt_r[2]};
			REG_HIST_SEL: return {1'b1, 28'h0, hist_sel_r};
			REG_HIST_STAMP: return {1'b1, hist_rec.stamp};
			REG_HIST_INFO: return {1'b1, 21'h0, hist_rec.group, hist_rec.phases, hist_rec.evt};
			REG_HIST_CUR: return {1'b1, hist_rec.pre_trig, hist_rec.fault};
			REG_HIST_PRE: return {1'b1, 16'h0, hist_rec.pre_fault};
			REG_HIST_REM: return {1'b1, 13'h0, hist_rec.remain};
			default: return {1'b0, 32'h0};
		endcase
	endfunction : ocs_read

	function automatic logic ocs_pickup(input logic held, input logic [15:0] mag,
			input logic [15:0] lvl);
		logic [23:0] m;
		logic [23:0] l;
		m = 24'(mag) * 24'(FULL_PCT);
		l = 24'(lvl) * 24'(REL_PCT);
		return held ? (m >= l) : (mag > lvl);
	endfunction : ocs_pickup

	function automatic logic [4:0] ocs_first(input logic [NUM_EVT-1:0] v);
		logic [4:0] idx;
		idx = 5'h00;
		for (int i = NUM_EVT - 1; i >= 0; i--) begin
			if (v[i])
				idx = 5'(i);
		end
		return idx;
	endfunction : ocs_first

	// AXI write: address and data taken in either order, response after both
	assign wr_fire = aw_hold_r && w_hold_r && !bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			aw_addr_r <= '0;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_hold_r <= 1'b1;
				w_data_r <= wdata;
				w_strb_r <= wstrb;
				wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// AXI read: one cycle from address to data; unmapped answers SLVERR
	always_comb begin
		{rd_ok, rd_word} = ocs_read(araddr);
		{wr_ok, wr_old} = ocs_read(aw_addr_r);
		wr_word = ocs_wmask(wr_old, w_data_r, w_strb_r);
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// Settings; counter clear is a write-one strobe that reads back zero
	assign cnt_clr = wr_fire && aw_addr_r == REG_CTRL && w_strb_r[0] && w_data_r[CTRL_CLR_BIT];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			inv_mode_r <= 1'b0;
			inrush_en_r <= 1'b0;
			evmask_r <= EVMASK_RST;
			pickup_r <= PICKUP_RST;
			harm_lim_r <= HARM_LIM_RST;
			delay_r <= DELAY_RST;
			release_r <= RELEASE_RST;
			hist_sel_r <= 4'h0;
		end else if (wr_fire) begin
			unique case (aw_addr_r)
				REG_CTRL: begin
					inv_mode_r <= wr_word[CTRL_INV_BIT];
					inrush_en_r <= wr_word[CTRL_INRUSH_BIT];
				end
				REG_EVMASK: evmask_r <= wr_word[NUM_EVT-1:0];
				REG_PICKUP: pickup_r <= wr_word[15:0];
				REG_HARM: harm_lim_r <= wr_word[15:0];
				REG_DELAY: delay_r <= wr_word[TW-1:0];
				REG_RELEASE: release_r <= wr_word[TW-1:0];
				REG_HIST_SEL: hist_sel_r <= wr_word[3:0];
				default: ;
			endcase
		end
	end

	// Millisecond stamp and 5 ms program-cycle tick from the system clock
	assign ms_pulse = (cyc_r == 32'(MS_CYC - 1));
	assign tick = ms_pulse && (tick_ms_r == 3'(TICK_MS - 1));
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_r <= 32'h0;
			tick_ms_r <= 3'h0;
			stamp_r <= 32'h0;
		end else begin
			cyc_r <= ms_pulse ? 32'h0 : cyc_r + 32'h1;
			if (ms_pulse) begin
				stamp_r <= stamp_r + 32'h1;
				tick_ms_r <= tick ? 3'h0 : tick_ms_r + 3'h1;
			end
		end
	end

	// Per-phase pick-up with hysteresis and inrush comparison
	for (genvar p = 0; p < 3; p++) begin : g_ph
		assign pk_nxt[p] = ocs_pickup(pk_r[p], measured_magnitude[p], pickup_r);
		assign harm_over[p] = harm_ratio[p] > harm_lim_r;
	end

	// Stage decision; block_in is only looked at on the tick edge
	always_comb begin
		max_mag = measured_magnitude[0];
		for (int p = 1; p < 3; p++) begin
			if (measured_magnitude[p] > max_mag)
				max_mag = measured_magnitude[p];
		end
		any_pk = |pk_nxt;
		harm_blk = inrush_en_r && |harm_over;
		start_nxt = any_pk && !block_in;
		blocked_nxt = any_pk && block_in;
		elapsed_inc = (elapsed_r == TW'(REMAIN_MAX_TICKS)) ? elapsed_r : elapsed_r + 1'b1;
		acc_inc = acc_r + 40'(max_mag);
		thr = 40'(delay_r) * 40'(pickup_r);
		// Inverse mode integrates current: time scales with level over magnitude
		done = inv_mode_r ? (acc_inc >= thr) : (elapsed_inc >= delay_r);
		trip_nxt = start_nxt && (stat_r.trip || done) && !harm_blk;
		remain_nxt = (start_nxt && !trip_nxt && delay_r > elapsed_inc) ? delay_r - elapsed_inc
				: '0;
		stat_nxt = {pk_nxt & {3{trip_nxt}}, pk_nxt & {3{start_nxt}}, blocked_nxt, trip_nxt,
				start_nxt};
		rise = stat_nxt & ~stat_r;
		ev_chg = stat_nxt ^ stat_r;
	end

	// Timer: release time runs the same way after drop-out or a block
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pk_r <= 3'h0;
			stat_r <= '0;
			elapsed_r <= '0;
			acc_r <= 40'h0;
			rel_r <= '0;
			remain_r <= '0;
		end else if (tick) begin
			pk_r <= pk_nxt;
			stat_r <= stat_nxt;
			remain_r <= remain_nxt;
			if (start_nxt) begin
				elapsed_r <= elapsed_inc;
				acc_r <= acc_inc;
				rel_r <= '0;
			end else if (rel_r + 1'b1 >= release_r) begin
				elapsed_r <= '0;
				acc_r <= 40'h0;
				rel_r <= '0;
			end else begin
				rel_r <= rel_r + 1'b1;
			end
		end
	end
	assign stat_o = stat_r;

	// Cumulative counters; a rise in the clearing cycle still counts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int c = 0; c < 3; c++)
				cnt_r[c] <= 32'h0;
		end else begin
			for (int c = 0; c < 3; c++)
				cnt_r[c] <= (cnt_clr ? 32'h0 : cnt_r[c]) + 32'(tick && rise[c]);
		end
	end

	// Event selection: even bit is assertion, odd bit deassertion
	for (genvar k = 0; k < NUM_EVT; k++) begin : g_ev
		assign ev_set[k] = tick && evmask_r[k] && ev_chg[k/2]
				&& (stat_nxt[k/2] == ((k % 2) == 0));
	end
	assign ev_clr = pend_r & (~pend_r + 1'b1);

	// One event per cycle, lowest code first; new events win over the drain
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_r <= '0;
			evt_valid <= 1'b0;
			evt_code <= 5'h00;
			evt_stamp <= 32'h0;
		end else begin
			pend_r <= (pend_r & ~ev_clr) | ev_set;
			evt_valid <= |pend_r;
			evt_code <= ocs_first(pend_r);
			if (tick)
				evt_stamp <= stamp_r;
		end
	end

	// Tick-spaced current history for the pre-trigger and pre-fault values
	assign pre_idx = (hp_r >= 6'(PRE_TRIG_TICKS)) ? hp_r - 6'(PRE_TRIG_TICKS)
			: hp_r + 6'(PRE_FAULT_TICKS - PRE_TRIG_TICKS);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hp_r <= 6'h00;
			for (int i = 0; i < PRE_FAULT_TICKS; i++)
				cur_hist[i] <= 16'h0000;
		end else if (tick) begin
			cur_hist[hp_r] <= max_mag;
			hp_r <= (hp_r == 6'(PRE_FAULT_TICKS - 1)) ? 6'h00 : hp_r + 6'h01;
		end
	end

	// Record on assertion only; trip outranks blocked outranks start
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rec_wr_r <= 1'b0;
			rec_r <= '0;
		end else begin
			rec_wr_r <= tick && (rise.start || rise.trip || rise.blocked);
			if (tick) begin
				rec_r.stamp <= stamp_r;
				rec_r.evt <= rise.trip ? EV_TRIP_ON : rise.blocked ? EV_BLOCK_ON : EV_START_ON;
				rec_r.phases <= pk_nxt;
				rec_r.pre_trig <= cur_hist[pre_idx];
				rec_r.fault <= max_mag;
				rec_r.pre_fault <= cur_hist[hp_r];
				rec_r.remain <= remain_nxt;
				rec_r.group <= group_in;
			end
		end
	end

	ocs_history u_hist (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(rec_wr_r),
		.wr_rec(rec_r),
		.rd_age(hist_sel_r),
		.rd_rec(hist_rec),
		.fill()
	);

	// Checks
	tick_hold_a: assert property (!tick |=> $stable(stat_r)) else $error("state moved off tick");
	start_go_a: assert property (tick && any_pk && !block_in |=> stat_r.start)
		else $error("start missing");
	blocked_a: assert property (tick && any_pk && block_in |=> stat_r.blocked
			&& !stat_r.start && !stat_r.trip) else $error("block ignored");
	blk_drop_a: assert property (stat_r.start && tick && block_in |=> !stat_r.start
			&& (elapsed_r == 0 || rel_r != 0 || release_r <= 1)) else $error("start kept");
	inrush_veto_a: assert property (tick && harm_blk |=> !stat_r.trip)
		else $error("trip under inrush");
	trip_start_a: assert property (stat_r.trip |-> stat_r.start) else $error("trip alone");
	mask_out_a: assert property (ev_set != 0 |-> ##[1:2] evt_valid)
		else $error("event lost");
	rec_on_a: assert property (rec_wr_r |-> !rec_r.evt[0] && $past(tick))
		else $error("record on release");
	cnt_clr_a: assert property (cnt_clr && !tick |=> cnt_r[0] == 0)
		else $error("counter not cleared");
endmodule : ocs_stage

// [verif/ocs_blk_model.sv]
// Far-side model: blocking matrix and user logic beside one stage.
// Assumes the bench commands blocking and reads back the user view.
`timescale 1ns/1ps
module ocs_blk_model
	import ocs_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic blk_cmd,
	input wire ocs_stat_t stat_o,
	output logic block_in,
	output logic [2:0] user_view
);
	// Matrix forwards the command one clock late, far ahead of any delay expiry
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			block_in <= 1'h0;
		end else begin
			block_in <= blk_cmd;
		end
	end

	// User logic keeps its own copy of the blocked, trip and start outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			user_view <= 3'h0;
		end else begin
			user_view <= {stat_o.blocked, stat_o.trip, stat_o.start};
		end
	end
endmodule : ocs_blk_model

// [verif/tb_top.sv]
// Self-checking bench for one overcurrent stage over AXI4-Lite.
// Assumes a shortened millisecond (MS_CYC 4), so one tick is 20 clocks.
`timescale 1ns/1ps
module tb_top
	import ocs_pkg::*;
;
	localparam int MSC = 4;
	localparam int TK = 5 * MSC;
	localparam logic [AW-1:0] RA [7] = '{REG_CTRL, REG_EVMASK, REG_PICKUP, REG_HARM,
		REG_DELAY, REG_RELEASE, REG_CNT_START};
	localparam logic [31:0] RV [7] = '{32'h0, 32'h3FFFF, 32'h78, 32'h1, 32'hC8, 32'h0, 32'h0};
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [AW-1:0] awaddr = 8'h00;
	logic [AW-1:0] araddr = 8'h00;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic blk_cmd = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	ocs_phase_t mag = 48'h0;
	ocs_phase_t harm = 48'h0;
	logic [2:0] grp = 3'h5;
	logic awready, wready, bvalid, arready, rvalid, evt_valid, block_in;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, evt_stamp, rd;
	logic [4:0] evt_code;
	logic [2:0] user_view;
	ocs_stat_t stat_o;
	int bad_count = 0;
	int compares = 0;
	logic [4:0] evc [$];
	logic [31:0] evs [$];

	// Free-running system clock
	always #2.5 aclk = ~aclk;

	ocs_stage #(.MS_CYC(MSC)) ocs_stage_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .measured_magnitude(mag),
		.harm_ratio(harm), .block_in, .group_in(grp), .stat_o, .evt_valid, .evt_code,
		.evt_stamp);

	ocs_blk_model ocs_blk_model_i (.aclk, .aresetn, .blk_cmd, .stat_o, .block_in, .user_view);

	// Event consumer: the pulse has no ready, so every valid cycle is taken
	always @(posedge aclk) begin
		if (evt_valid === 1'h1) begin
			evc.push_back(evt_code);
			evs.push_back(evt_stamp);
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Write: address and data offered together, each dropped once taken
	// No local limit: only the watchdog ends a wait that never gets its answer
	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready === 1'h1) awvalid <= 1'h0;
			if (wready === 1'h1) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		rs = bresp;
		bready <= 1'h0;
	endtask : wr

	task automatic rg(input logic [AW-1:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready === 1'h1) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rd = rdata;
		rs = rresp;
		rready <= 1'h0;
	endtask : rg

	task automatic tk(input int n);
		repeat (n * TK) @(posedge aclk);
	endtask : tk

	// Stamp of the first captured event with this code; all ones if absent
	function automatic logic [31:0] st_of(input logic [4:0] c);
		foreach (evc[i]) if (evc[i] === c) return evs[i];
		return 32'hFFFFFFFF;
	endfunction : st_of

	task automatic report_and_stop();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	// Watchdog: the tests need about 1800 clocks
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		report_and_stop();
	end

	// Test sequence
	initial begin
		int odd;
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 7; i++) begin
			rg(RA[i]);
			chk("reset value", rd, RV[i]);
		end
		rg(8'h40);
		chk("unmapped resp", 32'(rs), 32'(RESP_SLVERR));
		$display("test reset done");
		// Fixed delay of 3 ticks, fault on phase B
		wr(REG_PICKUP, 32'h64);
		wr(REG_DELAY, 32'h3);
		chk("write resp", 32'(rs), 32'(RESP_OKAY));
		evc.delete();
		evs.delete();
		mag[1] <= 16'h96;
		tk(5);
		chk("stat", 32'(stat_o), 32'h93);
		chk("user view", 32'(user_view), 32'h3);
		chk("event count", 32'(evc.size()), 32'h4);
		chk("event codes", {12'h0, evc[0], evc[1], evc[2], evc[3]}, 32'h0000204E);
		chk("trip delay", st_of(5'h02) - st_of(5'h00), 32'(2 * TICK_MS));
		mag[1] <= 16'h62;
		tk(2);
		chk("hysteresis hold", 32'(stat_o.start), 32'h1);
		mag[1] <= 16'h60;
		tk(2);
		chk("released", 32'(stat_o), 32'h0);
		$display("test fixed done");
		// Blocking before and during start
		wr(REG_DELAY, 32'hA);
		blk_cmd <= 1'h1;
		mag[0] <= 16'h96;
		tk(2);
		chk("blocked", 32'(stat_o[2:0]), 32'h4);
		blk_cmd <= 1'h0;
		tk(2);
		chk("unblocked", 32'(stat_o[2:0]), 32'h1);
		blk_cmd <= 1'h1;
		tk(2);
		chk("start dropped", 32'(stat_o[2:0]), 32'h4);
		for (int i = 0; i < 3; i++) begin
			rg(REG_CNT_START + 8'(4 * i));
			chk("counter", rd, 32'(2 - (i & 1)));
		end
		wr(REG_CTRL, 32'h4);
		for (int i = 0; i < 3; i++) begin
			rg(REG_CNT_START + 8'(4 * i));
			chk("counter clear", rd, 32'h0);
		end
		blk_cmd <= 1'h0;
		mag[0] <= 16'h0;
		tk(2);
		$display("test block done");
		// Inrush veto holds the trip while the ratio exceeds the limit
		wr(REG_CTRL, 32'h2);
		wr(REG_HARM, 32'h3E8);
		wr(REG_DELAY, 32'h3);
		harm[0] <= 16'h7D0;
		mag[0] <= 16'h96;
		tk(6);
		chk("inrush veto", 32'(stat_o[2:0]), 32'h1);
		harm[0] <= 16'h0;
		tk(3);
		chk("inrush gone", 32'(stat_o[2:0]), 32'h3);
		mag[0] <= 16'h0;
		tk(2);
		$display("test inrush done");
		// Inverse mode: heavy current trips well before the fixed figure
		wr(REG_CTRL, 32'h1);
		wr(REG_DELAY, 32'h5);
		evc.delete();
		evs.delete();
		mag[2] <= 16'h3E8;
		tk(4);
		chk("inverse time", 32'(st_of(5'h02) - st_of(5'h00) <= 32'(TICK_MS)), 32'h1);
		wr(REG_EVMASK, 32'h15555);
		evc.delete();
		mag[2] <= 16'h0;
		tk(3);
		mag[2] <= 16'h96;
		tk(3);
		odd = 0;
		foreach (evc[i]) odd += int'(evc[i][0]);
		chk("masked off events", 32'(odd), 32'h0);
		chk("on event kept", 32'(evc.size() > 0), 32'h1);
		$display("test inverse and mask done");
		// History: sixteen records from alternating block, newest a start
		wr(REG_DELAY, 32'hC8);
		mag[2] <= 16'h0;
		blk_cmd <= 1'h1;
		tk(2);
		mag[0] <= 16'h96;
		tk(1);
		for (int i = 0; i < 7; i++) begin
			blk_cmd <= 1'h0;
			tk(2);
			blk_cmd <= 1'h1;
			tk(2);
		end
		blk_cmd <= 1'h0;
		tk(2);
		wr(REG_HIST_SEL, 32'h0);
		rg(REG_HIST_INFO);
		chk("newest info", rd, 32'h520);
		rg(REG_HIST_CUR);
		chk("newest currents", rd, 32'h00960096);
		wr(REG_HIST_SEL, 32'h1);
		rg(REG_HIST_INFO);
		chk("older event", 32'(rd[4:0]), 32'(EV_BLOCK_ON));
		wr(REG_HIST_SEL, 32'hB);
		rg(REG_HIST_STAMP);
		chk("oldest kept", 32'(rd != 32'h0), 32'h1);
		wr(REG_HIST_SEL, 32'hC);
		rg(REG_HIST_STAMP);
		chk("beyond depth", rd, 32'h0);
		wr(REG_HIST_SEL, 32'h0);
		rg(REG_HIST_REM);
		chk("newest time left", rd, 32'hC7);
		wr(8'h40, 32'h1);
		chk("unmapped write", 32'(rs), 32'(RESP_SLVERR));
		mag[0] <= 16'h0;
		$display("test history done");
		// Release time of 3 ticks: a one-tick block must not lose the elapsed time
		blk_cmd <= 1'h1;
		wr(REG_CTRL, 32'h0);
		wr(REG_RELEASE, 32'h3);
		wr(REG_DELAY, 32'h4);
		mag[0] <= 16'h96;
		// Keep block changes and checks well away from the tick edges
		repeat (10) @(posedge aclk);
		tk(4);
		blk_cmd <= 1'h0;
		tk(2);
		blk_cmd <= 1'h1;
		tk(1);
		blk_cmd <= 1'h0;
		tk(2);
		chk("release keeps time", 32'(stat_o[2:0]), 32'h3);
		blk_cmd <= 1'h1;
		mag[0] <= 16'h0;
		$display("test release done");
		report_and_stop();
	end
endmodule : tb_top
